// >>> src/burst_addr_counter.v
// Two-bit burst address counter of the burst static RAM.
// Assumes load and step come from decode on the same clock; order select is static.
`timescale 1ns/100ps
`include "sync_burst_sram_consts.vh"

module burst_addr_counter #(
  parameter BURST_W = `SRAM_BURST_W
) (
  input wire clock,
  input wire reset_n,
  input wire load,
  input wire [BURST_W-1:0] load_bits,
  input wire step,
  input wire burst_order_sel,
  output wire [BURST_W-1:0] current_low,
  output wire [BURST_W-1:0] next_low
);

reg [BURST_W-1:0] start_bits;
reg [BURST_W-1:0] count;
wire [BURST_W-1:0] count_plus;

assign count_plus = count + {{(BURST_W-1){1'b0}}, 1'b1};

// Linear adds the count to the start, interleaved XORs it
assign current_low = (burst_order_sel == `SRAM_ORDER_INTERLEAVED) ? (start_bits ^ count) :
                     (start_bits + count);
assign next_low = (burst_order_sel == `SRAM_ORDER_INTERLEAVED) ? (start_bits ^ count_plus) :
                  (start_bits + count_plus);

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    start_bits <= {BURST_W{1'b0}};
    count <= {BURST_W{1'b0}};
  end else if (load) begin
    start_bits <= load_bits;
    count <= {BURST_W{1'b0}};
  end else if (step) begin
    count <= count_plus;
  end
end

endmodule // burst_addr_counter

// >>> src/sync_burst_sram.v
// Synchronous flow-through burst static RAM: capture registers, burst control,
// self-timed byte writes and a flow-through read path.
// Assumes all synchronous pins are launched on the same clock by the host;
// the output enable is asynchronous and the burst-order select is static.
`timescale 1ns/100ps
`include "sync_burst_sram_consts.vh"

// Notes on behaviour
// - 128K words of 36 bits, one port
// - Capture registers plus two-bit burst counter
// - All synchronous inputs registered on rising edge
// - Either address strobe starts a burst
// - Processor strobe ignored while primary enable high
// - Primary enable high blocks processor strobe, deselects
// - Secondary enable active high qualifies new access
// - Advance input steps the burst counter
// - Burst-order select unregistered, held static
// - Low order select picks linear sequence
// - Write starts on clock edge, self-timed
// - Each lane select governs its own lane
// - Byte write writes only selected lanes
// - Global write or all selects write all
// - Read data flows through without output register
// - Output enable high floats data asynchronously
// - Third enable active low qualifies new access
// - Linear order increments modulo four
// - Interleaved order XORs start with count
module sync_burst_sram #(
  parameter ADDR_W = `SRAM_ADDR_W,
  parameter DEPTH = `SRAM_DEPTH,
  parameter LANES = `SRAM_LANES,
  parameter LANE_W = `SRAM_LANE_W
) (
  input wire clock,
  input wire reset_n,
  input wire [ADDR_W-1:0] word_address,
  input wire proc_addr_strobe_n,
  input wire ctrl_addr_strobe_n,
  input wire burst_advance_n,
  input wire primary_chip_en_n,
  input wire expand_chip_en,
  input wire expand_chip_en_n,
  input wire global_write_n,
  input wire byte_write_en_n,
  input wire [LANES-1:0] lane_write_sel_n,
  input wire output_enable_n,
  input wire burst_order_sel,
  input wire [LANES*LANE_W-1:0] byte_lane_data_in,
  output wire [LANES*LANE_W-1:0] byte_lane_data_out,
  output wire byte_lane_data_oe_n
);

////////////////////////////////////////////////////////////////////////////////
// Cycle kinds decoded from the captured controls

localparam [1:0] CYCLE_IDLE = 2'h0;
localparam [1:0] CYCLE_DESELECT = 2'h1;
localparam [1:0] CYCLE_BEGIN = 2'h2;
localparam [1:0] CYCLE_CONTINUE = 2'h3;

localparam DATA_W = LANES * LANE_W;
localparam BURST_W = `SRAM_BURST_W;

////////////////////////////////////////////////////////////////////////////////
// Input capture registers

reg [ADDR_W-1:0] cap_addr;
reg [DATA_W-1:0] cap_data;
reg cap_proc_strobe_n;
reg cap_ctrl_strobe_n;
reg cap_advance_n;
reg cap_ce1_n;
reg cap_ce2;
reg cap_ce3_n;
reg cap_global_write_n;
reg cap_byte_write_n;
reg [LANES-1:0] cap_lane_sel_n;

// Address and write data
always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    cap_addr <= `SRAM_RST_ADDR;
    cap_data <= `SRAM_RST_DATA;
  end else begin
    cap_addr <= word_address;
    cap_data <= byte_lane_data_in;
  end
end

// Strobes, enables and write controls
always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    cap_proc_strobe_n <= `SRAM_RST_STROBE_N;
    cap_ctrl_strobe_n <= `SRAM_RST_STROBE_N;
    cap_advance_n <= `SRAM_RST_ADV_N;
    cap_ce1_n <= `SRAM_RST_CE1_N;
    cap_ce2 <= `SRAM_RST_CE2;
    cap_ce3_n <= `SRAM_RST_CE3_N;
    cap_global_write_n <= `SRAM_RST_GW_N;
    cap_byte_write_n <= `SRAM_RST_BW_N;
    cap_lane_sel_n <= `SRAM_RST_SEL_N;
  end else begin
    cap_proc_strobe_n <= proc_addr_strobe_n;
    cap_ctrl_strobe_n <= ctrl_addr_strobe_n;
    cap_advance_n <= burst_advance_n;
    cap_ce1_n <= primary_chip_en_n;
    cap_ce2 <= expand_chip_en;
    cap_ce3_n <= expand_chip_en_n;
    cap_global_write_n <= global_write_n;
    cap_byte_write_n <= byte_write_en_n;
    cap_lane_sel_n <= lane_write_sel_n;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Burst state

reg selected;
reg [ADDR_W-BURST_W-1:0] burst_high;
reg [1:0] cycle_kind;
reg next_selected;
reg counter_load;
reg counter_step;
reg access_write;
wire proc_start;
wire ctrl_start;
wire depth_match;
wire [BURST_W-1:0] current_low;
wire [BURST_W-1:0] next_low;
reg [ADDR_W-1:0] access_addr;
reg [LANES-1:0] write_lanes;

// Processor strobe only counts with the primary enable low
assign proc_start = !cap_proc_strobe_n && !cap_ce1_n;
// Controller strobe starts when processor strobe did not
assign ctrl_start = !cap_ctrl_strobe_n && !proc_start;
assign depth_match = cap_ce2 && !cap_ce3_n;

always @* begin
  cycle_kind = CYCLE_IDLE;
  if (proc_start) begin
    if (depth_match) begin
      cycle_kind = CYCLE_BEGIN;
    end else begin
      cycle_kind = CYCLE_DESELECT;
    end
  end else if (ctrl_start) begin
    if (!cap_ce1_n && depth_match) begin
      cycle_kind = CYCLE_BEGIN;
    end else begin
      cycle_kind = CYCLE_DESELECT;
    end
  end else if (selected) begin
    cycle_kind = CYCLE_CONTINUE;
  end
end

// Counter loads on a begin and moves only on continue beats
always @* begin
  next_selected = selected;
  counter_load = 1'b0;
  counter_step = 1'b0;
  case (cycle_kind)
    CYCLE_BEGIN: begin
      next_selected = 1'b1;
      counter_load = 1'b1;
    end
    CYCLE_DESELECT: begin
      next_selected = 1'b0;
    end
    CYCLE_CONTINUE: begin
      counter_step = !cap_advance_n;
    end
    default: begin
      next_selected = selected;
    end
  endcase
end

burst_addr_counter #(
  .BURST_W(BURST_W)
) u_counter (
  .clock(clock),
  .reset_n(reset_n),
  .load(counter_load),
  .load_bits(cap_addr[BURST_W-1:0]),
  .step(counter_step),
  .burst_order_sel(burst_order_sel),
  .current_low(current_low),
  .next_low(next_low)
);

// New burst uses the captured address; later beats take counter low bits
always @* begin
  case (cycle_kind)
    CYCLE_BEGIN: begin
      access_addr = cap_addr;
    end
    CYCLE_CONTINUE: begin
      if (counter_step) begin
        access_addr = {burst_high, next_low};
      end else begin
        access_addr = {burst_high, current_low};
      end
    end
    default: begin
      access_addr = {burst_high, current_low};
    end
  endcase
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    selected <= 1'b0;
  end else begin
    selected <= next_selected;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    burst_high <= {(ADDR_W-BURST_W){1'b0}};
  end else if (counter_load) begin
    burst_high <= cap_addr[ADDR_W-1:BURST_W];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Write decode

// A processor-strobe start is always a read
always @* begin
  case (cycle_kind)
    CYCLE_BEGIN: begin
      access_write = !proc_start;
    end
    CYCLE_CONTINUE: begin
      access_write = 1'b1;
    end
    default: begin
      access_write = 1'b0;
    end
  endcase
end

// Global write overrides the lane selects; byte write passes lanes whose selects are low
always @* begin
  if (!access_write) begin
    write_lanes = {LANES{1'b0}};
  end else if (!cap_global_write_n) begin
    write_lanes = {LANES{1'b1}};
  end else if (!cap_byte_write_n) begin
    write_lanes = ~cap_lane_sel_n;
  end else begin
    write_lanes = {LANES{1'b0}};
  end
end

////////////////////////////////////////////////////////////////////////////////
// Array, one storage bank per byte lane

genvar lane;
generate
  for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
    reg [LANE_W-1:0] bank [0:DEPTH-1];

    // Written at the edge closing the access cycle, no external pulse
    always @(posedge clock) begin
      if (write_lanes[lane]) begin
        bank[access_addr] <= cap_data[lane*LANE_W +: LANE_W];
      end
    end

    assign byte_lane_data_out[lane*LANE_W +: LANE_W] = bank[access_addr];
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Output drivers

reg read_cycle;
reg drive_off;

// A selected cycle that writes no lane is a read
always @* begin
  case (cycle_kind)
    CYCLE_BEGIN, CYCLE_CONTINUE: begin
      read_cycle = (write_lanes == {LANES{1'b0}});
    end
    default: begin
      read_cycle = 1'b0;
    end
  endcase
end

// Output enable acts without the clock; drivers stay off during writes
always @* begin
  if (output_enable_n) begin
    drive_off = 1'b1;
  end else begin
    drive_off = !read_cycle;
  end
end

assign byte_lane_data_oe_n = drive_off;

endmodule // sync_burst_sram

// >>> src/sync_burst_sram_consts.vh
// Constants for the synchronous flow-through burst static RAM.
// Assumes it is included by bare name from files under src/.
`ifndef SYNC_BURST_SRAM_CONSTS_VH
`define SYNC_BURST_SRAM_CONSTS_VH

// Array shape
`define SRAM_ADDR_W 17
`define SRAM_DEPTH 131072
`define SRAM_LANES 4
`define SRAM_LANE_W 9
`define SRAM_DATA_W 36

// Burst counter
`define SRAM_BURST_W 2
`define SRAM_BURST_LEN 4

// Field positions inside the registered word address
`define SRAM_LOW_LSB 0
`define SRAM_HIGH_LSB 2

// Reset values of the capture registers (all controls inactive)
`define SRAM_RST_STROBE_N 1'h1
`define SRAM_RST_ADV_N 1'h1
`define SRAM_RST_CE1_N 1'h1
`define SRAM_RST_CE2 1'h0
`define SRAM_RST_CE3_N 1'h1
`define SRAM_RST_GW_N 1'h1
`define SRAM_RST_BW_N 1'h1
`define SRAM_RST_SEL_N 4'hF
`define SRAM_RST_ADDR 17'h00000
`define SRAM_RST_DATA 36'h000000000

// Burst-order select encodings
`define SRAM_ORDER_LINEAR 1'h0
`define SRAM_ORDER_INTERLEAVED 1'h1

`endif

// >>> verification/host_bus_model.sv
// Host model driving the burst static RAM bus.
// Assumes one command per clock; command bits oe_n,ce1_n,ce2,ce3_n,strobes,adv,writes,lanes.
`timescale 1ns/100ps
module host_bus_model (
  input wire clock,
  output reg [12:0] ctl,
  output reg [16:0] word_address,
  output reg [35:0] byte_lane_data_in,
  output reg output_enable_n,
  output reg burst_order_sel
);
  reg wr_prev = 1'h0;
  initial begin
    ctl = 13'h1FFF;
    word_address = 17'h00000;
    byte_lane_data_in = 36'h000000000;
    output_enable_n = 1'h1;
    burst_order_sel = 1'h0;
  end
  task drive(input [12:0] c, input [16:0] a, input [35:0] d);
    reg wr;
    begin
      @(posedge clock);
      #1;
      wr = c[8] && !(c[5] && c[4]);
      output_enable_n = c[12] || wr || wr_prev;
      word_address = a;
      // Released data lines never keep the last value
      byte_lane_data_in = wr ? d : ~byte_lane_data_in;
      wr_prev = wr;
      ctl = c;
      #1;
    end
  endtask
  task set_order(input o);
    begin
      @(posedge clock);
      #1;
      burst_order_sel = o;
    end
  endtask
endmodule // host_bus_model

// >>> verification/sram_checker_properties.sv
// Pin-level checker for the burst static RAM.
// Assumes it is bound to sync_burst_sram and sees its ports only.
`timescale 1ns/100ps
module sram_checker (
  input wire clock,
  input wire reset_n,
  input wire proc_addr_strobe_n,
  input wire ctrl_addr_strobe_n,
  input wire burst_advance_n,
  input wire primary_chip_en_n,
  input wire expand_chip_en,
  input wire expand_chip_en_n,
  input wire global_write_n,
  input wire byte_write_en_n,
  input wire output_enable_n,
  input wire [35:0] byte_lane_data_out,
  input wire byte_lane_data_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire rd = global_write_n && byte_write_en_n;
  wire en = !primary_chip_en_n && expand_chip_en && !expand_chip_en_n;
  wire cs = !ctrl_addr_strobe_n && proc_addr_strobe_n;
  sequence s_go; cs && en && rd; endsequence
  sequence s_on; !output_enable_n; endsequence
  sequence s_pass; !proc_addr_strobe_n && primary_chip_en_n && ctrl_addr_strobe_n && rd; endsequence
  sequence s_hold; proc_addr_strobe_n && ctrl_addr_strobe_n && burst_advance_n && rd; endsequence
  property p_gate; output_enable_n |-> byte_lane_data_oe_n; endproperty
  a_gate: assert property (p_gate) else $error("pins driven while disabled");
  property p_cbeg; s_go ##1 s_on |-> !byte_lane_data_oe_n; endproperty
  a_cbeg: assert property (p_cbeg) else $error("read not driven");
  property p_pbeg; !proc_addr_strobe_n && en ##1 s_on |-> !byte_lane_data_oe_n; endproperty
  a_pbeg: assert property (p_pbeg) else $error("processor read not driven");
  property p_desel; !ctrl_addr_strobe_n && primary_chip_en_n |=> byte_lane_data_oe_n; endproperty
  a_desel: assert property (p_desel) else $error("deselect drove pins");
  property p_ce2; cs && !expand_chip_en |=> byte_lane_data_oe_n; endproperty
  a_ce2: assert property (p_ce2) else $error("high enable ignored");
  property p_ce3; cs && expand_chip_en_n |=> byte_lane_data_oe_n; endproperty
  a_ce3: assert property (p_ce3) else $error("low enable ignored");
  property p_pign; s_go ##1 s_pass ##1 s_on |-> !byte_lane_data_oe_n; endproperty
  a_pign: assert property (p_pign) else $error("blocked strobe deselected");
  property p_susp; s_go ##1 s_hold |=> $stable(byte_lane_data_out); endproperty
  a_susp: assert property (p_susp) else $error("suspend moved address");
endmodule // sram_checker

bind sync_burst_sram sram_checker u_checker (.clock(clock), .reset_n(reset_n),
  .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
  .burst_advance_n(burst_advance_n), .primary_chip_en_n(primary_chip_en_n), .expand_chip_en(expand_chip_en),
  .expand_chip_en_n(expand_chip_en_n), .global_write_n(global_write_n), .byte_write_en_n(byte_write_en_n),
  .output_enable_n(output_enable_n), .byte_lane_data_out(byte_lane_data_out),
  .byte_lane_data_oe_n(byte_lane_data_oe_n));

// >>> verification/tb_top.sv
// Self-checking bench for the burst static RAM.
// Assumes the host model issues all bus commands.
`timescale 1ns/100ps
module tb_top;
  reg clock = 1'b0;
  reg reset_n = 1'b0;
  wire [12:0] ctl;
  wire [16:0] addr;
  wire [35:0] din;
  wire [35:0] dout;
  wire g_n;
  wire order;
  wire oe_n;
  reg [35:0] mem [0:7];
  integer err_total = 0;
  integer check_count = 0;
  integer cycles = 0;
  integer i;
  always #10 clock = ~clock;
  host_bus_model u_host (.clock(clock), .ctl(ctl), .word_address(addr), .byte_lane_data_in(din),
    .output_enable_n(g_n), .burst_order_sel(order));
  sync_burst_sram u_dut (.clock(clock), .reset_n(reset_n), .word_address(addr), .proc_addr_strobe_n(ctl[8]),
    .ctrl_addr_strobe_n(ctl[7]), .burst_advance_n(ctl[6]), .primary_chip_en_n(ctl[11]), .expand_chip_en(ctl[10]),
    .expand_chip_en_n(ctl[9]), .global_write_n(ctl[5]), .byte_write_en_n(ctl[4]), .lane_write_sel_n(ctl[3:0]),
    .output_enable_n(g_n), .burst_order_sel(order), .byte_lane_data_in(din), .byte_lane_data_out(dout),
    .byte_lane_data_oe_n(oe_n));
  task chk(input string name, input [35:0] seen, input [35:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task look(input integer a, input o);
    begin
      chk("read data", dout, mem[a]);
      chk("pin enable", {35'h0, oe_n}, {35'h0, o});
    end
  endtask
  task go(input [12:0] c, input [16:0] a);
    u_host.drive(c, a, 36'h000000000);
  endtask
  task t_write_burst;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        u_host.drive(i ? 13'h059F : 13'h055F, 17'h00005, 36'h111111111 * (i + 1));
        mem[4 + ((1 + i) & 3)] = 36'h111111111 * (i + 1);
      end
      // End the burst so the held write command is not repeated
      go(13'h1D7F, 17'h00000);
    end
  endtask
  task t_read_burst(input o);
    integer k;
    begin
      u_host.set_order(o);
      go(13'h057F, 17'h00005);
      for (i = 0; i < 5; i = i + 1) begin
        go(i ? 13'h05BF : 13'h05FF, 17'h00000);
        k = i ? i - 1 : 0;
        look(4 + (o ? (1 ^ k) : ((1 + k) & 3)), 1'h0);
      end
    end
  endtask
  task t_lanes;
    begin
      go(13'h055F, 17'h00000);
      mem[0] = 36'h000000000;
      for (i = 0; i < 6; i = i + 1) begin
        u_host.drive(i < 4 ? 13'h0560 | (13'h000F ^ (13'h0001 << i)) : (i == 4 ? 13'h0560 : 13'h0570),
          17'h00000, i == 4 ? 36'h123456789 : 36'hFFFFFFFFF);
        if (i < 4)
          mem[0] = mem[0] | (36'h0000001FF << (9 * i));
        else if (i == 4)
          mem[0] = 36'h123456789;
        go(13'h057F, 17'h00000);
        go(13'h05BF, 17'h00000);
        look(0, 1'h0);
      end
    end
  endtask
  task t_select;
    begin
      go(13'h057F, 17'h00005);
      go(13'h0CBF, 17'h00000);
      look(5, 1'h0);
      go(13'h05BF, 17'h00000);
      look(6, 1'h0);
      go(13'h15BF, 17'h00000);
      look(7, 1'h1);
      for (i = 0; i < 4; i = i + 1) begin
        go(i == 0 ? 13'h0D7F : (i == 1 ? 13'h017F : (i == 2 ? 13'h077F : 13'h00FF)), 17'h00005);
        go(13'h05BF, 17'h00000);
        chk("deselect", {35'h0, oe_n}, 36'h000000001);
      end
      go(13'h04DF, 17'h00006);
      go(13'h05BF, 17'h00000);
      look(6, 1'h0);
      go(13'h04FF, 17'h00006);
      go(13'h05BF, 17'h00000);
      look(6, 1'h0);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    #1;
    reset_n = 1'b1;
    t_write_burst;
    t_read_burst(1'h0);
    t_read_burst(1'h1);
    u_host.set_order(1'h0);
    t_lanes;
    t_select;
    end_of_test;
  end
endmodule // tb_top
